// *** core/akr_pkg.sv ***
package akr_pkg;
	// ------------------------------------------------------------
	// Serial register map
	// ------------------------------------------------------------
	localparam logic [4:0]  AKR_ADDR_CTRL     = 5'h00; // Keying control bits
	localparam logic [4:0]  AKR_ADDR_RAMP     = 5'h01; // Amplitude scale and ramp word
	localparam logic [4:0]  AKR_ADDR_STATUS   = 5'h02; // Live ramp word, read only
	localparam int          AKR_INSTR_BITS    = 8;     // Instruction phase length
	localparam int          AKR_DATA_BITS     = 32;    // Data phase length
	localparam int          AKR_INSTR_RD_POS  = 7;     // Read flag in instruction
	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int          AKR_CTRL_EN_POS     = 0;   // Keying enable
	localparam int          AKR_CTRL_AUTO_POS   = 1;   // Auto ramp select
	localparam int          AKR_CTRL_GATE_POS   = 2;   // Manual pin gate enable
	localparam int          AKR_CTRL_RELOAD_POS = 3;   // Reload timer on update
	localparam logic [3:0]  AKR_CTRL_RESET      = 4'h0;
	// ------------------------------------------------------------
	// Amplitude scale and ramp register fields
	// ------------------------------------------------------------
	localparam int          AKR_RATE_LSB      = 16;    // Step interval, bits 31:16
	localparam int          AKR_RATE_W        = 16;
	localparam int          AKR_MAX_LSB       = 2;     // Maximum scale, bits 15:2
	localparam int          AKR_AMP_W         = 14;
	localparam int          AKR_STEP_LSB      = 0;     // Step size code, bits 1:0
	localparam int          AKR_STEP_W        = 2;
	localparam logic [31:0] AKR_RAMP_RESET    = 32'h0000_0000;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          AKR_TICK_DIV      = 4;     // Timer runs at a quarter of the clock
endpackage : akr_pkg

// *** core/akr_tick_div.sv ***
`timescale 1ns/1ps
// Quarter-rate enable, held in reset while gated off
module akr_tick_div
	import akr_pkg::*;
(
	input  wire logic CLK_SYS,
	input  wire logic RST_B,
	input  wire logic run,
	output logic      tick
);
	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	logic [1:0] cnt_reg; // Phase within the quarter period

	// Counter frozen and cleared while stopped to save power
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			cnt_reg <= 2'h0;
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 2'h0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 2'h1;
			tick    <= (cnt_reg == 2'(AKR_TICK_DIV - 1));
		end
	end
endmodule : akr_tick_div

// *** core/akr_step_timer.sv ***
`timescale 1ns/1ps
// Step interval timer: one pulse every M ticks
module akr_step_timer #(
	parameter int W = 16
) (
	input  wire logic         CLK_SYS,
	input  wire logic         RST_B,
	input  wire logic         tick,
	input  wire logic         reload,
	input  wire logic [W-1:0] interval,
	output logic              expire
);
	// ------------------------------------------------------------
	// Down counter
	// ------------------------------------------------------------
	logic [W-1:0] cnt_reg;  // Ticks left in this interval
	logic [W-1:0] load_val; // Value that gives exactly M ticks

	// Zero interval behaves as one tick, the fastest rate
	assign load_val = (interval == '0) ? '0 : interval - W'(1);

	// Early reload wins over counting
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			cnt_reg <= '0;
			expire  <= 1'b0;
		end else if (reload) begin
			cnt_reg <= load_val;
			expire  <= 1'b0;
		end else if (tick) begin
			expire  <= (cnt_reg == '0);
			cnt_reg <= (cnt_reg == '0) ? load_val : cnt_reg - W'(1);
		end else begin
			expire  <= 1'b0;
		end
	end
endmodule : akr_step_timer

// *** core/akr_keying.sv ***
`timescale 1ns/1ps
module akr_keying
	import akr_pkg::*;
#(
	parameter int PROFILE_W = 3
) (
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST_B,
	input  wire logic                 SINGLE_TONE_MODE,
	input  wire logic                 AMP_KEYING_PIN,
	input  wire logic                 IO_UPDATE,
	input  wire logic [PROFILE_W-1:0] PROFILE,
	input  wire logic                 SCLK,
	input  wire logic                 CS_B,
	input  wire logic                 SDI,
	output logic                      SDO,
	output logic [AKR_AMP_W-1:0]      AMP_RAMP_WORD,
	output logic [AKR_AMP_W-1:0]      AMP_SCALE,
	output logic                      AMP_KEY_ACTIVE
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 5 + PROFILE_W;
	logic [NSYNC-1:0] pin_raw;  // Asynchronous pins gathered
	logic [NSYNC-1:0] sync1_reg; // First stage, read only by second
	logic [NSYNC-1:0] sync2_reg; // Safe to use
	logic [NSYNC-1:0] prev_reg;  // For edge detection

	assign pin_raw = {PROFILE, AMP_KEYING_PIN, IO_UPDATE, SCLK, CS_B, SDI};

	// Two flops per pin, then one more for edges
	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_sync
			always_ff @(posedge CLK_SYS or negedge RST_B) begin
				if (!RST_B) begin
					sync1_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
					prev_reg[i]  <= 1'b0;
				end else begin
					sync1_reg[i] <= pin_raw[i];
					sync2_reg[i] <= sync1_reg[i];
					prev_reg[i]  <= sync2_reg[i];
				end
			end
		end
	endgenerate

	logic sdi_s, cs_b_s, sclk_rise, sclk_fall, upd_rise, key_pin, key_edge, prof_chg;
	assign sdi_s     = sync2_reg[0];
	assign cs_b_s    = sync2_reg[1];
	assign sclk_rise = sync2_reg[2] & ~prev_reg[2];
	assign sclk_fall = ~sync2_reg[2] & prev_reg[2];
	assign upd_rise  = sync2_reg[3] & ~prev_reg[3];
	assign key_pin   = sync2_reg[4];
	assign key_edge  = sync2_reg[4] ^ prev_reg[4];
	assign prof_chg  = (sync2_reg[NSYNC-1:5] != prev_reg[NSYNC-1:5]);

	// ------------------------------------------------------------
	// Serial port: 8-bit instruction, 32-bit data, MSB first
	// ------------------------------------------------------------
	logic [5:0]  bit_cnt_reg;  // Bits received in this frame
	logic [7:0]  instr_reg;    // Read flag and address
	logic [31:0] shin_reg;     // Write data shift register
	logic [31:0] shout_reg;    // Read data shift register
	logic [3:0]  ctrl_buf_reg; // Written control, not yet applied
	logic [31:0] ramp_buf_reg; // Written ramp word, not yet applied
	logic        wr_done;      // Last data bit of a write
	logic        instr_done;   // Last instruction bit

	assign instr_done = sclk_rise && !cs_b_s && (bit_cnt_reg == 6'(AKR_INSTR_BITS - 1));
	assign wr_done    = sclk_rise && !cs_b_s && !instr_reg[AKR_INSTR_RD_POS]
	                    && (bit_cnt_reg == 6'(AKR_INSTR_BITS + AKR_DATA_BITS - 1));

	// Read data mux, unmapped addresses read zero
	function automatic logic [31:0] rd_mux(input logic [4:0] a, input logic [3:0] c,
	                                       input logic [31:0] r, input logic [13:0] w);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			AKR_ADDR_CTRL:   v = {28'h0000000, c};
			AKR_ADDR_RAMP:   v = r;
			AKR_ADDR_STATUS: v = {18'h00000, w};
			default:         v = 32'h0000_0000;
		endcase
		return v;
	endfunction : rd_mux

	// Bit counter and instruction capture; frame ends on chip select high
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			bit_cnt_reg <= 6'h00;
			instr_reg   <= 8'h00;
			shin_reg    <= 32'h0000_0000;
		end else if (cs_b_s) begin
			bit_cnt_reg <= 6'h00;
		end else if (sclk_rise) begin
			if (bit_cnt_reg < 6'(AKR_INSTR_BITS)) begin
				instr_reg <= {instr_reg[6:0], sdi_s};
			end else begin
				shin_reg <= {shin_reg[30:0], sdi_s};
			end
			if (bit_cnt_reg != 6'h3F) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	// Read shifter loads after instruction, shifts on falling edge
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			shout_reg <= 32'h0000_0000;
			SDO       <= 1'b0;
		end else if (instr_done) begin
			shout_reg <= rd_mux({instr_reg[3:0], sdi_s}, ctrl_buf_reg, ramp_buf_reg, AMP_RAMP_WORD);
		end else if (sclk_fall && !cs_b_s && instr_reg[AKR_INSTR_RD_POS]
		             && bit_cnt_reg >= 6'(AKR_INSTR_BITS)) begin
			SDO       <= shout_reg[31];
			shout_reg <= {shout_reg[30:0], 1'b0};
		end else if (cs_b_s) begin
			SDO <= 1'b0;
		end
	end

	// Buffered registers: writes land here only
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_buf_reg <= AKR_CTRL_RESET;
			ramp_buf_reg <= AKR_RAMP_RESET;
		end else if (wr_done) begin
			if (instr_reg[4:0] == AKR_ADDR_CTRL) begin
				ctrl_buf_reg <= {shin_reg[2:0], sdi_s};
			end else if (instr_reg[4:0] == AKR_ADDR_RAMP) begin
				ramp_buf_reg <= {shin_reg[30:0], sdi_s};
			end
		end
	end

	// ------------------------------------------------------------
	// Active registers, applied on update or profile change
	// ------------------------------------------------------------
	logic                  load_active; // Update edge or profile change
	logic [3:0]            ctrl_act_reg;
	logic [31:0]           ramp_act_reg;
	logic                  en_act, auto_act, gate_act, reload_act;
	logic [AKR_RATE_W-1:0] rate_act;
	logic [AKR_AMP_W-1:0]  max_act;
	logic [AKR_STEP_W-1:0] step_code;

	assign load_active = upd_rise | prof_chg;

	// Transfer buffered values into the working logic
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_act_reg <= AKR_CTRL_RESET;
			ramp_act_reg <= AKR_RAMP_RESET;
		end else if (load_active) begin
			ctrl_act_reg <= ctrl_buf_reg;
			ramp_act_reg <= ramp_buf_reg;
		end
	end

	// Keying only matters in single-tone mode
	assign en_act     = ctrl_act_reg[AKR_CTRL_EN_POS] & SINGLE_TONE_MODE;
	assign auto_act   = ctrl_act_reg[AKR_CTRL_AUTO_POS];
	assign gate_act   = ctrl_act_reg[AKR_CTRL_GATE_POS];
	assign reload_act = ctrl_act_reg[AKR_CTRL_RELOAD_POS];
	assign rate_act   = ramp_act_reg[AKR_RATE_LSB +: AKR_RATE_W];
	assign max_act    = ramp_act_reg[AKR_MAX_LSB +: AKR_AMP_W];
	assign step_code  = ramp_act_reg[AKR_STEP_LSB +: AKR_STEP_W];

	// ------------------------------------------------------------
	// Step timing
	// ------------------------------------------------------------
	logic tick;        // Quarter-rate enable
	logic step_pulse;  // Timer expiry
	logic timer_rel;   // Early reload request
	logic auto_rise;   // Auto bit goes 0 to 1 on this update
	logic tick_run;    // Tick seen only while enabled
	logic [AKR_RATE_W-1:0] rate_load; // Interval taken by a load

	assign auto_rise = load_active & ~auto_act & ctrl_buf_reg[AKR_CTRL_AUTO_POS];
	assign timer_rel = auto_rise
	                   | (key_edge & en_act)
	                   | (load_active & reload_act);

	// A tick launched just before disable would otherwise fire one stray step
	assign tick_run  = tick & en_act;
	// A reload made by the update itself must use the interval that update applies
	assign rate_load = load_active ? ramp_buf_reg[AKR_RATE_LSB +: AKR_RATE_W] : rate_act;

	// Clocks stopped whenever keying is off
	akr_tick_div u_div (
		.CLK_SYS (CLK_SYS),
		.RST_B   (RST_B),
		.run     (en_act),
		.tick    (tick)
	);

	// Self-reloading interval timer, M ticks of four clocks
	akr_step_timer #(
		.W (AKR_RATE_W)
	) u_timer (
		.CLK_SYS  (CLK_SYS),
		.RST_B    (RST_B),
		.tick     (tick_run),
		.reload   (timer_rel),
		.interval (rate_load),
		.expire   (step_pulse)
	);

	// ------------------------------------------------------------
	// Amplitude ramp
	// ------------------------------------------------------------
	logic [AKR_AMP_W-1:0] step_amt;   // Decoded step size
	logic [AKR_AMP_W:0]   up_sum;     // Extra bit catches overflow
	logic [AKR_AMP_W-1:0] ramp_next;

	// Step code to LSB weight
	function automatic logic [AKR_AMP_W-1:0] step_decode(input logic [1:0] c);
		return AKR_AMP_W'(1) << c;
	endfunction : step_decode

	assign step_amt = step_decode(step_code);
	assign up_sum   = {1'b0, AMP_RAMP_WORD} + {1'b0, step_amt};

	// Next ramp value, clamped at both ends
	always_comb begin
		ramp_next = AMP_RAMP_WORD;
		if (!en_act || !auto_act) begin
			ramp_next = '0;
		end else if (AMP_RAMP_WORD > max_act) begin
			ramp_next = max_act;
		end else if (step_pulse) begin
			if (key_pin) begin
				ramp_next = (up_sum > {1'b0, max_act}) ? max_act : up_sum[AKR_AMP_W-1:0];
			end else begin
				ramp_next = (AMP_RAMP_WORD < step_amt) ? '0 : AMP_RAMP_WORD - step_amt;
			end
		end
	end

	// Ramp word register, zero out of reset
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			AMP_RAMP_WORD <= '0;
		end else begin
			AMP_RAMP_WORD <= ramp_next;
		end
	end

	// Scale word: manual uses the field, auto uses the ramp
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			AMP_SCALE      <= '0;
			AMP_KEY_ACTIVE <= 1'b0;
		end else begin
			AMP_KEY_ACTIVE <= en_act;
			if (!en_act) begin
				AMP_SCALE <= '0;
			end else if (auto_act) begin
				AMP_SCALE <= ramp_next;
			end else if (gate_act && !key_pin) begin
				AMP_SCALE <= '0;
			end else begin
				AMP_SCALE <= max_act;
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_OFF_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!en_act |=> (AMP_RAMP_WORD == '0) && (AMP_SCALE == '0))
		else $error("ramp word not zero while keying off");
	AST_MANUAL_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && !auto_act) |=> (AMP_RAMP_WORD == '0))
		else $error("ramp word not zero in manual mode");
	AST_NO_TICK_OFF: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!en_act [*2] |-> !tick && !step_pulse)
		else $error("keying clocks run while disabled");
	AST_GATE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && !auto_act && gate_act && !key_pin) |=> (AMP_SCALE == '0))
		else $error("pin gate failed to force zero");
	AST_MANUAL_SCALE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && !auto_act && (!gate_act || key_pin)) |=> (AMP_SCALE == $past(max_act)))
		else $error("manual scale not the programmed factor");
	AST_NOT_ABOVE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && auto_act && step_pulse) |=> (AMP_RAMP_WORD <= $past(max_act)))
		else $error("ramp above maximum");
	AST_STEP_UP: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && auto_act && step_pulse && key_pin && up_sum <= {1'b0, max_act})
		|=> (AMP_RAMP_WORD == $past(AMP_RAMP_WORD) + $past(step_amt)))
		else $error("upward step wrong");
	AST_STEP_DOWN: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && auto_act && step_pulse && !key_pin && AMP_RAMP_WORD <= max_act)
		|=> (AMP_RAMP_WORD == (($past(AMP_RAMP_WORD) < $past(step_amt)) ? '0
		                       : $past(AMP_RAMP_WORD) - $past(step_amt))))
		else $error("downward step wrong");
	AST_QUARTER: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		step_pulse |=> !step_pulse [*3])
		else $error("steps closer than four clocks");
	AST_PIN_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(key_edge && en_act && rate_act >= 16'h0002 && !load_active) |=> !step_pulse [*5])
		else $error("pin change did not restart interval");
	AST_APPLY: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!load_active |=> $stable(ctrl_act_reg) && $stable(ramp_act_reg))
		else $error("active values changed without update");
	AST_SINGLE_TONE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!SINGLE_TONE_MODE |=> !AMP_KEY_ACTIVE)
		else $error("keying active outside single tone");
	AST_AUTO_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(auto_rise && rate_load >= 16'h0002) |=> !step_pulse [*5])
		else $error("auto select rise did not restart interval");
	AST_UPD_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(load_active && reload_act && rate_load >= 16'h0002) |=> !step_pulse [*5])
		else $error("update did not restart interval");
	AST_CLAMP_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && auto_act && step_pulse && !key_pin && AMP_RAMP_WORD <= max_act && AMP_RAMP_WORD < step_amt)
		|=> (AMP_RAMP_WORD == '0))
		else $error("downward ramp did not stop at zero");
	AST_AUTO_SCALE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(en_act && auto_act) |=> (AMP_SCALE == AMP_RAMP_WORD))
		else $error("applied scale differs from ramp word");
endmodule : akr_keying

// *** dv/akr_ctrl_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// External controller: serial writes, update strobe, keying pin
// ------------------------------------------------------------
module akr_ctrl_model
	import akr_pkg::*;
(
	input  wire logic CLK_SYS,        // System clock
	input  wire logic SDO,            // Serial read data
	output logic      AMP_KEYING_PIN, // Keying pin level
	output logic      IO_UPDATE,      // Update strobe
	output logic [2:0] PROFILE,       // Profile pins
	output logic      SCLK,           // Serial clock, still outside frames
	output logic      CS_B,           // Serial select, active low
	output logic      SDI             // Serial write data
);
	// Idle levels at time zero
	initial begin
		AMP_KEYING_PIN = 1'b0;
		IO_UPDATE      = 1'b0;
		PROFILE        = 3'h0;
		SCLK           = 1'b0;
		CS_B           = 1'b1;
		SDI            = 1'b0;
	end
	// One 40-bit frame; SCLK high 5 clocks and low 6 clocks, keeping above the 4 clock minimum
	task automatic frame(input logic [7:0] instr, input logic [31:0] wdata, output logic [31:0] rdata);
		logic [39:0] sh;
		sh    = {instr, wdata};
		rdata = '0;
		@(posedge CLK_SYS) CS_B <= 1'b0;
		for (int i = 39; i >= 0; i--) begin
			@(posedge CLK_SYS) SDI <= sh[i];
			repeat (5) @(posedge CLK_SYS);
			SCLK <= 1'b1;
			// Read bit was shifted out on the previous fall
			if (i < 32) begin
				rdata[i] = SDO;
			end
			repeat (5) @(posedge CLK_SYS);
			SCLK <= 1'b0;
		end
		// Hold select until the word has landed, then scramble the idle data line
		repeat (6) @(posedge CLK_SYS);
		CS_B <= 1'b1;
		SDI  <= ~SDI;
	endtask : frame
	task automatic write_reg(input logic [4:0] addr, input logic [31:0] data);
		logic [31:0] dummy;
		frame({3'h0, addr}, data, dummy);
	endtask : write_reg
	task automatic read_reg(input logic [4:0] addr, output logic [31:0] data);
		frame({3'h4, addr}, 32'h0000_0000, data);
	endtask : read_reg
	// Rising edge applies buffered values; held 3 clocks so the synchroniser sees it
	task automatic apply_update();
		@(posedge CLK_SYS) IO_UPDATE <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		IO_UPDATE <= 1'b0;
		repeat (8) @(posedge CLK_SYS);
	endtask : apply_update
	// Profile change applies buffered values as well
	task automatic set_profile(input logic [2:0] p);
		@(posedge CLK_SYS) PROFILE <= p;
		repeat (8) @(posedge CLK_SYS);
	endtask : set_profile
	// High asks for an upward ramp, low for a downward one
	task automatic set_pin(input logic v);
		@(posedge CLK_SYS) AMP_KEYING_PIN <= v;
	endtask : set_pin
endmodule : akr_ctrl_model

// *** dv/amplitude_keying_ramp_tb.sv ***
`timescale 1ns/1ps
module amplitude_keying_ramp_tb
	import akr_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        CLK_SYS;          // 10 MHz clock
	logic        RST_B;            // Async reset, active low
	logic        SINGLE_TONE_MODE; // Mode select from bench
	logic        pin, upd, sclk, cs_b, sdi, sdo, active;
	logic [2:0]  prof;             // Profile pins
	logic [13:0] AMP_RAMP_WORD;    // Ramp word seen
	logic [13:0] amp_scale;        // Applied scale seen
	logic [31:0] rd;               // Read-back scratch
	int          err_total;        // Mismatch count
	int          checked;          // Comparison count
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	akr_keying u_akr_keying (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SINGLE_TONE_MODE(SINGLE_TONE_MODE),
		.AMP_KEYING_PIN(pin), .IO_UPDATE(upd), .PROFILE(prof), .SCLK(sclk), .CS_B(cs_b), .SDI(sdi),
		.SDO(sdo), .AMP_RAMP_WORD(AMP_RAMP_WORD), .AMP_SCALE(amp_scale), .AMP_KEY_ACTIVE(active));
	akr_ctrl_model u_akr_ctrl_model (.CLK_SYS(CLK_SYS), .SDO(sdo), .AMP_KEYING_PIN(pin), .IO_UPDATE(upd),
		.PROFILE(prof), .SCLK(sclk), .CS_B(cs_b), .SDI(sdi));
	// Clock, 100 ns period
	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end
	// ------------------------------------------------------------
	// Compare and wait helpers
	// ------------------------------------------------------------
	task automatic test_done();
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg
	task automatic chk_amp(input string what, input logic [13:0] exp, input logic [13:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_amp
	task automatic chk_flag(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_flag
	// Clocks until the ramp word moves; a stuck word ends the run
	task automatic wait_change(output int n);
		logic [13:0] prev;
		prev = AMP_RAMP_WORD;
		n    = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (AMP_RAMP_WORD === prev && n < 3000);
		if (n >= 3000) begin
			err_total++;
			test_done();
		end
	endtask : wait_change
	// Bounded wait for the ramp word to come down to zero
	task automatic wait_zero();
		int n;
		n = 0;
		while (AMP_RAMP_WORD !== 14'h0000 && n < 8000) begin
			@(posedge CLK_SYS);
			n++;
		end
		if (n >= 8000) begin
			err_total++;
			test_done();
		end
	endtask : wait_zero
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset values, read-back, unmapped address
	task automatic sc_regs();
		chk_amp("word at reset", 14'h0000, AMP_RAMP_WORD);
		u_akr_ctrl_model.read_reg(AKR_ADDR_CTRL, rd);
		chk_reg("ctrl reset", {28'h0, AKR_CTRL_RESET}, rd);
		u_akr_ctrl_model.read_reg(AKR_ADDR_RAMP, rd);
		chk_reg("ramp reset", AKR_RAMP_RESET, rd);
		u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, 32'hA5C3_5A96);
		u_akr_ctrl_model.read_reg(AKR_ADDR_RAMP, rd);
		chk_reg("ramp readback", 32'hA5C3_5A96, rd);
		u_akr_ctrl_model.read_reg(5'h1F, rd);
		chk_reg("unmapped read", 32'h0000_0000, rd);
	endtask : sc_regs
	// Manual mode: nothing moves before the update, then the pin gates
	task automatic sc_manual();
		u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, 32'h0000_048C); // Maximum 0x123
		u_akr_ctrl_model.write_reg(AKR_ADDR_CTRL, 32'h0000_0005);
		chk_flag("active before update", 1'b0, active);
		u_akr_ctrl_model.apply_update();
		chk_amp("gated low", 14'h0000, amp_scale);
		u_akr_ctrl_model.set_pin(1'b1);
		repeat (8) @(posedge CLK_SYS);
		chk_amp("gated high", 14'h0123, amp_scale);
		chk_amp("manual word", 14'h0000, AMP_RAMP_WORD);
		u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, 32'h0000_0154); // Maximum 0x55
		chk_amp("held until update", 14'h0123, amp_scale);
		u_akr_ctrl_model.write_reg(AKR_ADDR_CTRL, 32'h0000_0001);
		u_akr_ctrl_model.apply_update();
		u_akr_ctrl_model.set_pin(1'b0);
		repeat (8) @(posedge CLK_SYS);
		chk_amp("pin ignored", 14'h0055, amp_scale);
		// Outside single tone the keying has no effect
		SINGLE_TONE_MODE <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		chk_flag("active off tone", 1'b0, active);
		chk_amp("scale off tone", 14'h0000, amp_scale);
		SINGLE_TONE_MODE <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		chk_amp("scale back", 14'h0055, amp_scale);
	endtask : sc_manual
	// Ramp up to a maximum that is not a step multiple, then down
	task automatic sc_ramp();
		int n;
		u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, 32'h0002_002E); // M 2, maximum 11, step 4
		u_akr_ctrl_model.write_reg(AKR_ADDR_CTRL, 32'h0000_0003);
		u_akr_ctrl_model.apply_update();
		chk_flag("auto active", 1'b1, active);
		u_akr_ctrl_model.set_pin(1'b1);
		wait_change(n);
		chk_amp("up 1", 14'h0004, AMP_RAMP_WORD);
		wait_change(n);
		chk_amp("up 2", 14'h0008, AMP_RAMP_WORD);
		chk_reg("interval", 32'd8, n);
		wait_change(n);
		chk_amp("clamp max", 14'h000B, AMP_RAMP_WORD);
		repeat (30) @(posedge CLK_SYS);
		chk_amp("hold max", 14'h000B, AMP_RAMP_WORD);
		chk_amp("scale follows", 14'h000B, amp_scale);
		u_akr_ctrl_model.set_pin(1'b0);
		wait_change(n);
		chk_amp("down 1", 14'h0007, AMP_RAMP_WORD);
		wait_change(n);
		chk_amp("down 2", 14'h0003, AMP_RAMP_WORD);
		wait_change(n);
		chk_amp("clamp zero", 14'h0000, AMP_RAMP_WORD);
	endtask : sc_ramp
	// Every step code from zero
	task automatic sc_steps();
		int n;
		for (int c = 0; c < 4; c++) begin
			u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, {16'h0001, 14'h3FFF, 2'(c)});
			u_akr_ctrl_model.apply_update();
			u_akr_ctrl_model.set_pin(1'b0);
			wait_zero();
			u_akr_ctrl_model.set_pin(1'b1);
			wait_change(n);
			chk_amp("first step", 14'(1 << c), AMP_RAMP_WORD);
		end
	endtask : sc_steps
	// Disable applied by a profile change forces everything to zero
	task automatic sc_disable();
		u_akr_ctrl_model.write_reg(AKR_ADDR_CTRL, 32'h0000_0000);
		u_akr_ctrl_model.set_profile(3'h5);
		chk_flag("active off", 1'b0, active);
		chk_amp("word off", 14'h0000, AMP_RAMP_WORD);
		chk_amp("scale off", 14'h0000, amp_scale);
	endtask : sc_disable
	// Early timer restarts, then a reset in mid-run
	// Counts run from each task's return: 4M clocks less the sync and apply delays
	task automatic sc_reload();
		int n;
		u_akr_ctrl_model.write_reg(AKR_ADDR_RAMP, 32'h0014_FFFC); // M 20, maximum 0x3FFF, step 1
		u_akr_ctrl_model.write_reg(AKR_ADDR_CTRL, 32'h0000_000B);
		u_akr_ctrl_model.apply_update();
		wait_change(n);
		chk_reg("auto rise restart", 32'd75, n);
		repeat (40) @(posedge CLK_SYS);
		u_akr_ctrl_model.set_profile(3'h2);
		wait_change(n);
		chk_reg("profile restart", 32'd75, n);
		repeat (40) @(posedge CLK_SYS);
		u_akr_ctrl_model.apply_update();
		wait_change(n);
		chk_reg("update restart", 32'd72, n);
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		chk_flag("active in reset", 1'b0, active);
		chk_amp("word in reset", 14'h0000, AMP_RAMP_WORD);
		chk_amp("scale in reset", 14'h0000, amp_scale);
		RST_B <= 1'b1;
		repeat (5) @(posedge CLK_SYS);
		u_akr_ctrl_model.read_reg(AKR_ADDR_RAMP, rd);
		chk_reg("ramp after reset", AKR_RAMP_RESET, rd);
	endtask : sc_reload
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		err_total        = 0;
		checked          = 0;
		RST_B            = 1'b0;
		SINGLE_TONE_MODE = 1'b1;
		repeat (10) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		repeat (5) @(posedge CLK_SYS);
		sc_regs();
		sc_manual();
		sc_ramp();
		sc_steps();
		sc_disable();
		sc_reload();
		test_done();
	end
endmodule : amplitude_keying_ramp_tb
